// file: logic/ashp_consts.vh
// Constants for the converter serial host port
`ifndef ASHP_CONSTS_VH
`define ASHP_CONSTS_VH
`define ASHP_CMD_BITS 6'h08
`define ASHP_CMD_READ_BIT 7
`define ASHP_CMD_ADDR_MSB 3
`define ASHP_ADDR_CTRL 4'h1
`define ASHP_ADDR_STATUS 4'h2
`define ASHP_ADDR_RESULT 4'h3
`define ASHP_CTRL_BITS 6'h08
`define ASHP_STATUS_BITS 6'h08
`define ASHP_RESULT_BITS 6'h18
`define ASHP_CTRL_RESET 8'h00
`define ASHP_RESULT_RESET 24'h000000
`define ASHP_STATUS_LOW_SUPPLY_POS 0
`define ASHP_BIT_CNT_MAX 6'h3f
`define ASHP_PIN_RESET 4'h1
`define ASHP_SYNC_WARMUP 2'h3
`endif

// file: logic/ashp_port.v
// Serial host port of the panel-meter converter
`timescale 1ns/1ps
`include "ashp_consts.vh"
// Contract
// - Supply below threshold lights symbol and sets a sticky status flag.
// - End-of-conversion output goes low when a new result is stored.
// - Host holds select low per transfer; port answers only while selected.
// - Input bit captured on each serial clock rise while selected.
// - Port works with serial clock idling either high or low.
// - Output bit changes on each serial clock fall.
// - Serial output is high impedance while select is high.
// - Register contents shift out only after a read request.
module ashp_port #(
  parameter RESULT_WIDTH = 24
) (
  input wire CLK,
  input wire RST_B,
  input wire CS_B,
  input wire SCLK,
  input wire DIN,
  output reg DOUT,
  output reg DOUT_OE,
  output reg EOC_B,
  input wire LOW_SUPPLY_IN,
  output reg LOW_SUPPLY_SEG,
  input wire [RESULT_WIDTH-1:0] RESULT_DATA,
  input wire RESULT_LOAD,
  output reg [7:0] CTRL_OUT
);
  wire [3:0] pin_level;
  wire [3:0] pin_rise;
  wire [3:0] pin_fall;
  wire cs_b_s;
  wire sclk_rise;
  wire sclk_fall;
  wire din_s;
  wire low_supply_s;

  reg [5:0] bit_cnt;
  reg [7:0] cmd;
  reg [7:0] rx;
  reg [23:0] tx;
  reg reading;
  reg [3:0] read_addr;
  reg [23:0] result;
  reg low_supply_flag;
  reg [1:0] warm;
  reg [7:0] status_word;

  wire selected;
  wire link_ready;
  wire cmd_done;
  wire [7:0] cmd_next;
  wire [7:0] rx_next;
  wire cmd_is_read;
  wire [3:0] cmd_addr;
  wire ctrl_write;
  wire result_read_done;

  // Selects the word a read request will shift out, MSB first
  function [23:0] read_word;
    input [3:0] addr;
    input [7:0] ctrl;
    input [7:0] status;
    input [23:0] res;
    begin
      case (addr)
        `ASHP_ADDR_CTRL: read_word = {ctrl, 16'h0000};
        `ASHP_ADDR_STATUS: read_word = {status, 16'h0000};
        `ASHP_ADDR_RESULT: read_word = res;
        default: read_word = 24'h000000;
      endcase
    end
  endfunction

  // Decodes the serial clock rise that carries frame bit n
  function bit_edge;
    input [5:0] cnt;
    input [5:0] n;
    begin
      bit_edge = (cnt == n - 6'h01);
    end
  endfunction

  // Pins from outside this clock domain
  ashp_sync #(
    .WIDTH(4),
    .RESET_VAL(`ASHP_PIN_RESET)
  ) u_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .async_in({LOW_SUPPLY_IN, DIN, SCLK, CS_B}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign cs_b_s = pin_level[0];
  assign link_ready = (warm == `ASHP_SYNC_WARMUP);
  assign sclk_rise = pin_rise[1] & link_ready;
  assign sclk_fall = pin_fall[1] & link_ready;
  assign din_s = pin_level[2];
  assign low_supply_s = pin_level[3];

  assign selected = ~cs_b_s;
  assign cmd_next = {cmd[6:0], din_s};
  assign rx_next = {rx[6:0], din_s};
  assign cmd_done = selected & sclk_rise & bit_edge(bit_cnt, `ASHP_CMD_BITS);
  assign cmd_is_read = cmd_next[`ASHP_CMD_READ_BIT];
  assign cmd_addr = cmd_next[`ASHP_CMD_ADDR_MSB:0];
  assign ctrl_write = selected & sclk_rise & ~reading & (read_addr == `ASHP_ADDR_CTRL) &
                      bit_edge(bit_cnt, `ASHP_CMD_BITS + `ASHP_CTRL_BITS);
  assign result_read_done = selected & sclk_rise & reading &
                            (read_addr == `ASHP_ADDR_RESULT) &
                            bit_edge(bit_cnt, `ASHP_CMD_BITS + `ASHP_RESULT_BITS);

  // Status word with the sticky flag at its field position
  always @* begin
    status_word = 8'h00;
    status_word[`ASHP_STATUS_LOW_SUPPLY_POS] = low_supply_flag;
  end

  // Warm-up: sync chain still holds reset values, not pin levels
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      warm <= 2'h0;
    end else if (warm != `ASHP_SYNC_WARMUP) begin
      warm <= warm + 2'h1;
    end
  end

  // Frame bit counter and command capture
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bit_cnt <= 6'h00;
      cmd <= 8'h00;
      rx <= 8'h00;
      reading <= 1'b0;
      read_addr <= 4'h0;
    end else if (!selected) begin
      bit_cnt <= 6'h00;
      reading <= 1'b0;
      read_addr <= 4'h0;
    end else if (sclk_rise) begin
      if (bit_cnt != `ASHP_BIT_CNT_MAX) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
      if (bit_cnt < `ASHP_CMD_BITS) begin
        cmd <= cmd_next;
      end else begin
        rx <= rx_next;
      end
      if (cmd_done) begin
        reading <= cmd_is_read;
        read_addr <= cmd_addr;
      end
    end
  end

  // Control register written by the host
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CTRL_OUT <= `ASHP_CTRL_RESET;
    end else if (ctrl_write) begin
      CTRL_OUT <= rx_next;
    end
  end

  // Transmit shifter, loaded at read command, advanced on falls
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx <= 24'h000000;
      DOUT <= 1'b0;
      DOUT_OE <= 1'b0;
    end else begin
      DOUT_OE <= selected;
      if (!selected) begin
        tx <= 24'h000000;
        DOUT <= 1'b0;
      end else if (cmd_done) begin
        if (cmd_is_read) begin
          tx <= read_word(cmd_addr, CTRL_OUT, status_word, result);
        end else begin
          tx <= 24'h000000;
        end
      end else if (sclk_fall && reading) begin
        DOUT <= tx[23];
        tx <= {tx[22:0], 1'b0};
      end else if (sclk_fall) begin
        DOUT <= 1'b0;
      end
    end
  end

  // Result register and end-of-conversion flag
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      result <= `ASHP_RESULT_RESET;
      EOC_B <= 1'b1;
    end else begin
      if (RESULT_LOAD) begin
        result <= RESULT_DATA[23:0];
      end
      if (RESULT_LOAD) begin
        EOC_B <= 1'b0;
      end else if (result_read_done) begin
        EOC_B <= 1'b1;
      end
    end
  end

  // Low-supply symbol and sticky flag; comparator output is active high
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      low_supply_flag <= 1'b0;
      LOW_SUPPLY_SEG <= 1'b0;
    end else begin
      LOW_SUPPLY_SEG <= low_supply_s;
      if (low_supply_s) begin
        low_supply_flag <= 1'b1;
      end
    end
  end
endmodule // ashp_port

// file: logic/ashp_sync.v
// Two-stage synchroniser with edge detection
`timescale 1ns/1ps
module ashp_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);
  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] sync;
  reg [WIDTH-1:0] last;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= RESET_VAL;
      sync <= RESET_VAL;
      last <= RESET_VAL;
    end else begin
      meta <= async_in;
      sync <= meta;
      last <= sync;
    end
  end

  assign level = sync;
  assign rise = sync & ~last;
  assign fall = ~sync & last;
endmodule // ashp_sync

// file: verif/ashp_host.sv
// Host model driving the serial link
`timescale 1ns/1ps
module ashp_host(
  input logic clk,
  input logic dout,
  output logic cs_b = 1'b1,
  output logic sclk = 1'b1,
  output logic din = 1'b0
);
  task automatic xfer(input logic cpol, input logic [31:0] tx, input int n,
    output logic [31:0] rx);
    rx = '0;
    sclk <= cpol;
    repeat (4) @(posedge clk);
    cs_b <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 31; i > 31 - n; i--) begin
      sclk <= 1'b0;
      din <= tx[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
      rx = {rx[30:0], dout};
      repeat (2) @(posedge clk);
    end
    sclk <= cpol;
    repeat (4) @(posedge clk);
    cs_b <= 1'b1;
    din <= ~din;
    repeat (6) @(posedge clk);
  endtask
endmodule // ashp_host

// file: verif/ashp_port_sva.sv
// Checker for the serial host port
`timescale 1ns/1ps
module ashp_port_chk(
  input logic CLK,
  input logic RST_B,
  input logic CS_B,
  input logic SCLK,
  input logic DOUT,
  input logic DOUT_OE,
  input logic EOC_B,
  input logic LOW_SUPPLY_IN,
  input logic LOW_SUPPLY_SEG,
  input logic RESULT_LOAD,
  input logic [7:0] CTRL_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence sel4; !CS_B[*4]; endsequence
  sequence desel4; CS_B[*4]; endsequence
  AST_OE_ON: assert property (sel4 |-> DOUT_OE) else $error("oe low");
  AST_HIZ: assert property (desel4 |-> !DOUT_OE && !DOUT) else $error("dout on");
  AST_DOUT_OE: assert property (DOUT |-> DOUT_OE) else $error("dout no oe");
  AST_SEG: assert property (LOW_SUPPLY_IN[*4] |-> LOW_SUPPLY_SEG) else $error("seg");
  AST_EOC: assert property (RESULT_LOAD |=> !EOC_B) else $error("eoc high");
  AST_EOC_CLR: assert property ($rose(EOC_B) |-> !CS_B) else $error("eoc clr");
  AST_DOUT_FALL: assert property ($changed(DOUT) && !CS_B |->
    $past(SCLK,5) && !$past(SCLK,3)) else $error("dout moved");
  AST_CTRL: assert property ($changed(CTRL_OUT) |-> !$past(CS_B,4) &&
    $past(SCLK,3) && !$past(SCLK,7)) else $error("ctrl moved");
endmodule // ashp_port_chk
bind ashp_port ashp_port_chk i_ashp_port_chk(
  .CLK(CLK),
  .RST_B(RST_B),
  .CS_B(CS_B),
  .SCLK(SCLK),
  .DOUT(DOUT),
  .DOUT_OE(DOUT_OE),
  .EOC_B(EOC_B),
  .LOW_SUPPLY_IN(LOW_SUPPLY_IN),
  .LOW_SUPPLY_SEG(LOW_SUPPLY_SEG),
  .RESULT_LOAD(RESULT_LOAD),
  .CTRL_OUT(CTRL_OUT)
);

// file: verif/ashp_port_test.sv
// Self-checking bench for the serial host port
`timescale 1ns/1ps
module ashp_port_test;
  typedef struct packed {logic c; logic [31:0] tx; int n; logic [23:0] m; logic [23:0] e;} ashp_row_t;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic LOW_SUPPLY_IN = 1'b0;
  logic RESULT_LOAD = 1'b0;
  logic [23:0] RESULT_DATA = 24'h000000;
  logic CS_B, SCLK, DIN, DOUT, DOUT_OE, EOC_B, LOW_SUPPLY_SEG;
  logic [7:0] CTRL_OUT;
  logic [31:0] rx;
  wire dout_pin;
  // Released pin seen as the inverse of DOUT, which deselect clears to 0
  assign dout_pin = DOUT_OE ? DOUT : ~DOUT;
  int bad_count = 0;
  int tests_run = 0;
  ashp_row_t rows[7] = '{
    '{1, 32'h01a50000, 16, 24'hffffff, 24'h000000},
    '{0, 32'h81000000, 32, 24'hff0000, 24'ha50000},
    '{0, 32'h015a0000, 16, 24'hffffff, 24'h000000},
    '{1, 32'h05ff0000, 16, 24'hffffff, 24'h000000},
    '{1, 32'h85000000, 32, 24'hffffff, 24'h000000},
    '{1, 32'h81000000, 32, 24'hff0000, 24'h5a0000},
    '{0, 32'h82000000, 32, 24'h010000, 24'h000000}};
  ashp_port i_ashp_port(
    .CLK(CLK),
    .RST_B(RST_B),
    .CS_B(CS_B),
    .SCLK(SCLK),
    .DIN(DIN),
    .DOUT(DOUT),
    .DOUT_OE(DOUT_OE),
    .EOC_B(EOC_B),
    .LOW_SUPPLY_IN(LOW_SUPPLY_IN),
    .LOW_SUPPLY_SEG(LOW_SUPPLY_SEG),
    .RESULT_DATA(RESULT_DATA),
    .RESULT_LOAD(RESULT_LOAD),
    .CTRL_OUT(CTRL_OUT)
  );
  ashp_host i_ashp_host(.clk(CLK), .dout(dout_pin), .cs_b(CS_B), .sclk(SCLK), .din(DIN));
  always #12.5 CLK = ~CLK;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #300us;
    bad_count++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (4) @(posedge CLK);
    foreach (rows[i]) begin
      i_ashp_host.xfer(rows[i].c, rows[i].tx, rows[i].n, rx);
      chk(rx[23:0] & rows[i].m, rows[i].e);
    end
    chk(CTRL_OUT, 32'h5a);
    // Aborted frame, then a clean read
    i_ashp_host.xfer(1, 32'h01000000, 4, rx);
    i_ashp_host.xfer(1, 32'h81000000, 32, rx);
    chk(rx[23:16], 32'h5a);
    RESULT_DATA <= 24'hc3a55a;
    RESULT_LOAD <= 1'b1;
    @(posedge CLK);
    RESULT_LOAD <= 1'b0;
    repeat (2) @(posedge CLK);
    chk(EOC_B, 0);
    i_ashp_host.xfer(0, 32'h83000000, 32, rx);
    chk(rx[23:0], 32'hc3a55a);
    chk(EOC_B, 1);
    LOW_SUPPLY_IN <= 1'b1;
    repeat (5) @(posedge CLK);
    chk(LOW_SUPPLY_SEG, 1);
    LOW_SUPPLY_IN <= 1'b0;
    repeat (5) @(posedge CLK);
    chk(LOW_SUPPLY_SEG, 0);
    i_ashp_host.xfer(1, 32'h82000000, 32, rx);
    chk(rx[16], 1);
    RST_B <= 1'b0;
    repeat (2) @(posedge CLK);
    chk({CTRL_OUT, EOC_B, DOUT_OE}, 32'h002);
    RST_B <= 1'b1;
    repeat (4) @(posedge CLK);
    i_ashp_host.xfer(0, 32'h82000000, 32, rx);
    chk(rx[23:16], 32'h00);
    end_sim;
  end
endmodule // ashp_port_test
